// ===== shared/trip_pkg.sv
// Package: timing constants and carrier types for the thermal trip latch
package trip_pkg;
    // Clock rate in kHz and the enable window in ns
    localparam int CLK_KHZ = 100000;
    localparam int EN_WINDOW_NS = 10000;
    // Longest time rounds down to whole cycles
    localparam int EN_WINDOW_CYC = (EN_WINDOW_NS * (CLK_KHZ / 1000)) / 1000;
    // Cycles the enable is set early to cover the input sync delay
    localparam int EN_MARGIN_CYC = 4;
    // Width of the window counter
    localparam int CNT_W = 11;
    // Reset values
    localparam logic TRIP_RST = 1'b0;
    localparam logic EN_RST = 1'b0;

    // Synchronised inputs travel together
    typedef struct packed {
        logic sensor_hot;
        logic power_good;
    } sync_in_s;

    // Latch states
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_ARM = 3'b010,
        ST_RUN = 3'b100
    } latch_state_e;
endpackage

// ===== core/trip_sync.sv
// Two-flop synchroniser for the sensor and power-good inputs
`timescale 1ns/10ps
module trip_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,            // System clock
    input wire logic rstn,               // Async reset, active low
    input wire logic [WIDTH-1:0] d_in,   // Raw inputs
    output logic [WIDTH-1:0] q_out       // Synchronised outputs
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // Next values: first stage read only by the second
    always_comb begin
        meta_nxt = d_in;
        sync_nxt = meta_r;
    end

    // Register both stages
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign q_out = sync_r;
endmodule

// ===== core/thermal_trip_latch.sv
// Thermal trip latch with power-good gating and clock stop
`timescale 1ns/10ps

// Notes on behaviour
// - Trip asserts when the sensor reports the damage threshold.
// - A trip stops the internal clocks so execution halts.
// - Output drive enables within 10 us of power-good, drops with it.
// - Trip stays latched until power-good deasserts.
// - A still-hot die retrips within 10 us of power-good returning.
module thermal_trip_latch #(
    parameter int WINDOW_CYC = trip_pkg::EN_WINDOW_CYC
) (
    input wire logic clk_sys,        // System clock, 100 MHz
    input wire logic rstn,           // Async reset, active low
    input wire logic sensor_hot,     // Sensor past trip level
    input wire logic power_good_in,  // Platform power good
    output logic trip_n_out,         // Trip pin level, active low
    output logic trip_oe,            // Trip pin drive enable
    output logic clk_stop            // Halt internal clocks
);
    ////////////////////////////////////////////////////////////////////////
    // Parameter check: the arm phase needs a count above the margin
    if (WINDOW_CYC <= trip_pkg::EN_MARGIN_CYC ||
        WINDOW_CYC >= (1 << trip_pkg::CNT_W)) begin : g_bad_window
        $error("WINDOW_CYC out of counter range");
    end
    // Last arm count, cut to the counter width on purpose
    localparam int ARM_LAST_I = WINDOW_CYC - trip_pkg::EN_MARGIN_CYC;
    localparam logic [trip_pkg::CNT_W-1:0] ARM_LAST =
        ARM_LAST_I[trip_pkg::CNT_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    trip_pkg::sync_in_s raw_in;
    trip_pkg::sync_in_s syn_in;
    logic [1:0] syn_bits;

    assign raw_in = '{sensor_hot: sensor_hot, power_good: power_good_in};
    trip_sync #(.WIDTH(2)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d_in(raw_in),
        .q_out(syn_bits)
    );
    assign syn_in = syn_bits;

    ////////////////////////////////////////////////////////////////////////
    // State, window counter and latch
    trip_pkg::latch_state_e state_r;
    trip_pkg::latch_state_e state_nxt;
    logic [trip_pkg::CNT_W-1:0] cnt_r;
    logic [trip_pkg::CNT_W-1:0] cnt_nxt;
    logic trip_r;
    logic trip_nxt;
    logic oe_r;
    logic oe_nxt;
    logic stop_r;
    logic stop_nxt;

    // Sensor is watched from power-good on, so a hot die retrips early
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        trip_nxt = trip_r;
        oe_nxt = oe_r;
        stop_nxt = stop_r;
        case (state_r)
            trip_pkg::ST_OFF: begin
                cnt_nxt = '0;
                if (syn_in.power_good) begin
                    state_nxt = trip_pkg::ST_ARM;
                end
            end
            trip_pkg::ST_ARM: begin
                cnt_nxt = cnt_r + 1'b1;
                // Margin covers the sync delay so the pin is on in time
                if (cnt_r >= ARM_LAST) begin
                    state_nxt = trip_pkg::ST_RUN;
                    oe_nxt = 1'b1;
                end
            end
            trip_pkg::ST_RUN: begin
                cnt_nxt = '0;
            end
            default: begin
                state_nxt = trip_pkg::ST_OFF;
                cnt_nxt = '0;
            end
        endcase
        if (syn_in.power_good && syn_in.sensor_hot) begin
            trip_nxt = 1'b1;
            stop_nxt = 1'b1;
        end
        // Only power-good loss clears the latch and drive
        if (!syn_in.power_good) begin
            state_nxt = trip_pkg::ST_OFF;
            trip_nxt = trip_pkg::TRIP_RST;
            stop_nxt = 1'b0;
            oe_nxt = trip_pkg::EN_RST;
            cnt_nxt = '0;
        end
    end

    // Register the group
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r <= trip_pkg::ST_OFF;
            cnt_r <= '0;
            trip_r <= trip_pkg::TRIP_RST;
            oe_r <= trip_pkg::EN_RST;
            stop_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            trip_r <= trip_nxt;
            oe_r <= oe_nxt;
            stop_r <= stop_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs: active low level, drive only when enabled
    logic pin_r;
    logic pin_nxt;
    logic pe_r;
    logic pe_nxt;
    always_comb begin
        pin_nxt = !trip_r;
        pe_nxt = oe_nxt;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_r <= 1'b1;
            pe_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
            pe_r <= pe_nxt;
        end
    end
    assign trip_n_out = pin_r;
    assign trip_oe = pe_r;
    assign clk_stop = stop_r;

    ////////////////////////////////////////////////////////////////////////
    // Check helper: cycles since synchronised power good rose
    logic [trip_pkg::CNT_W-1:0] pg_age_r;
    logic [trip_pkg::CNT_W-1:0] pg_age_nxt;
    // Window runs from the raw input; the age lags it by two edges,
    // so the bound does not lean on the design's own margin
    localparam int OE_AGE_I = WINDOW_CYC - 2;
    localparam logic [trip_pkg::CNT_W-1:0] OE_AGE =
        OE_AGE_I[trip_pkg::CNT_W-1:0];

    // Age saturates so a long powered run never wraps back to zero
    always_comb begin
        pg_age_nxt = pg_age_r;
        if (!syn_in.power_good) begin
            pg_age_nxt = '0;
        end else if (pg_age_r != '1) begin
            pg_age_nxt = pg_age_r + 1'b1;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pg_age_r <= '0;
        end else begin
            pg_age_r <= pg_age_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_hot_trips: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        syn_in.power_good && syn_in.sensor_hot |=> trip_r)
        else $error("trip not set on hot sensor");
    chk_clock_stops: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        trip_oe && !trip_n_out |-> clk_stop)
        else $error("clocks not stopped on trip");
    chk_drive_window: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        syn_in.power_good && pg_age_r >= OE_AGE |-> trip_oe)
        else $error("drive not enabled within window");
    chk_drive_drops: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        !syn_in.power_good |=> !trip_oe)
        else $error("drive not dropped with power good");
    chk_drive_needs_pg: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        trip_oe |-> $past(syn_in.power_good))
        else $error("pin driven without power good");
    chk_trip_holds: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        trip_r && syn_in.power_good |=> trip_r)
        else $error("trip released while powered");
    chk_retrip_hot: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(syn_in.power_good) && syn_in.sensor_hot |-> ##2 !trip_n_out)
        else $error("hot die did not retrip");
    chk_pin_cause: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        $fell(trip_n_out) |->
        $past(syn_in.sensor_hot, 2) && $past(syn_in.power_good, 2))
        else $error("pin fell without a powered hot sensor");
    chk_clear_off: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        !syn_in.power_good |=> !trip_r && !stop_r)
        else $error("latch not cleared on power loss");
    cov_trip: cover property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(trip_r));
    cov_enable: cover property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(trip_oe));
    cov_clear: cover property (
        @(posedge clk_sys) disable iff (!rstn)
        $fell(trip_r));
    cov_hot_power_up: cover property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(syn_in.power_good) && syn_in.sensor_hot);
    cov_trip_power_loss: cover property (
        @(posedge clk_sys) disable iff (!rstn)
        $fell(syn_in.power_good) && trip_r);
endmodule

// ===== tb/power_seq_model.sv
// Platform power sequencer model that cuts power after a sampled trip
`timescale 1ns/10ps
module power_seq_model #(
    parameter int WIN = 16
) (
    input wire logic clk_sys,    // System clock
    input wire logic rstn,       // Async reset, active low
    input wire logic pg_on,      // Bench asks for power
    input wire logic cut_en,     // Allow supply removal
    input wire logic trip_n_out, // Trip pin level
    input wire logic trip_oe,    // Trip pin drive enable
    output logic power_good_in   // Power good to the device
);
    logic [7:0] age_r;
    logic cut_r;
    logic pin_n;
    // Undriven pin idles high through the board pull-up
    assign pin_n = trip_oe ? trip_n_out : 1'b1;
    assign power_good_in = pg_on & ~cut_r;
    ////////////////////////////////////////////////////////////////////////
    // Age of power good; supply stays cut until the bench powers down
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            age_r <= 8'h00;
            cut_r <= 1'b0;
        end else begin
            age_r <= power_good_in ? age_r + ((age_r < 8'hff) ? 8'h01 : 8'h00)
                                   : 8'h00;
            if (!pg_on) begin
                cut_r <= 1'b0;
            end else if (age_r >= WIN && cut_en && !pin_n) begin
                cut_r <= 1'b1;
            end
        end
    end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the thermal trip latch
`timescale 1ns/10ps
module testbench;
    localparam int W = 16;
    logic clk_sys, rstn, sensor_hot, pg_on, cut_en, power_good_in;
    logic trip_n_out, trip_oe, clk_stop;
    int err_count, num_checks, cyc;
    thermal_trip_latch #(.WINDOW_CYC(W)) dut_u (.clk_sys(clk_sys),
        .rstn(rstn), .sensor_hot(sensor_hot), .power_good_in(power_good_in),
        .trip_n_out(trip_n_out), .trip_oe(trip_oe), .clk_stop(clk_stop));
    power_seq_model #(.WIN(W)) psu_u (.clk_sys(clk_sys), .rstn(rstn),
        .pg_on(pg_on), .cut_en(cut_en), .trip_n_out(trip_n_out),
        .trip_oe(trip_oe), .power_good_in(power_good_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic got, input logic exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic close_out();
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Power up cool: drive enabled within the window, pin idle high
    task automatic t_enable();
        pg_on = 1'b1;
        for (int i = 0; i < W && trip_oe !== 1'b1; i++) tick(1);
        chk(trip_oe, 1'b1, "drive not enabled");
        chk(trip_n_out, 1'b1, "false trip");
    endtask
    // Hot die trips, then stays latched after cooling
    task automatic t_latch();
        sensor_hot = 1'b1;
        tick(6);
        chk(clk_stop, 1'b1, "clocks not stopped");
        chk(trip_n_out, 1'b0, "no trip");
        sensor_hot = 1'b0;
        tick(40);
        chk(trip_n_out, 1'b0, "trip not latched");
        chk(clk_stop, 1'b1, "clock stop dropped");
    endtask
    // Power good low clears trip and drive; hot input ignored meanwhile
    task automatic t_clear();
        pg_on = 1'b0;
        tick(6);
        chk(trip_oe, 1'b0, "drive kept");
        chk(clk_stop, 1'b0, "trip not cleared");
        chk(trip_n_out, 1'b1, "trip pin held");
        sensor_hot = 1'b1;
        tick(6);
        chk(clk_stop, 1'b0, "trip while unpowered");
    endtask
    // Still hot at power up: retrip in the window, then supply is cut
    task automatic t_retrip();
        cut_en = 1'b1;
        pg_on = 1'b1;
        // Pin level falls early; drive only comes at the window's end
        for (int i = 0; i < W && (trip_oe !== 1'b1 || trip_n_out !== 1'b0);
             i++) tick(1);
        chk(trip_oe, 1'b1, "retrip not driven");
        chk(trip_n_out, 1'b0, "no retrip");
        for (int i = 0; i < 8 && power_good_in !== 1'b0; i++) tick(1);
        tick(6);
        chk(power_good_in, 1'b0, "supply not cut");
        chk(trip_oe, 1'b0, "drive after cut");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard well beyond the hundred or so cycles of the run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        rstn = 1'b0;
        sensor_hot = 1'b0;
        pg_on = 1'b0;
        cut_en = 1'b0;
        tick(6);
        chk(trip_n_out, 1'b1, "reset pin level");
        chk(trip_oe, 1'b0, "reset drive");
        rstn = 1'b1;
        tick(2);
        t_enable();
        t_latch();
        t_clear();
        t_retrip();
        close_out();
    end
endmodule
